// ---- hdl/fp_excp_elig.sv ----
// Purpose: Gates detected FP conditions by class eligibility into sticky flags
// Assumes: Detected conditions arrive with op_valid in the same cycle
// Notes:   Set wins over clear on the sticky flags
`timescale 1ns/1ps
module fp_excp_elig
  import fp_excp_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          op_valid,
  input  fp_excp_pkg::op_class_t             op_class,
  input  wire logic [fp_excp_pkg::IMM_W-1:0] imm,
  input  wire logic [fp_excp_pkg::EXC_W-1:0] detected,
  input  wire logic [fp_excp_pkg::EXC_W-1:0] flags_clear,
  output logic [fp_excp_pkg::EXC_W-1:0]      elig_mask,
  output logic [fp_excp_pkg::EXC_W-1:0]      raised_r,
  output logic [fp_excp_pkg::EXC_W-1:0]      flags_r
);
  import fp_excp_pkg::*;

  logic                 rst_meta_r;
  logic                 rst_sync_b_r;
  logic [EXC_W-1:0]     raised_nxt;
  logic [EXC_W-1:0]     flags_nxt;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r   <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_b_r <= rst_meta_r;
    end
  end

  fp_excp_decode u_decode (
    .op_class (op_class),
    .imm      (imm),
    .mask     (elig_mask)
  );

  // Only eligible conditions reach the flags
  assign raised_nxt = op_valid ? (detected & elig_mask) : FLAGS_RESET;
  assign flags_nxt  = (flags_r & ~flags_clear) | raised_nxt;

  always_ff @(posedge clock or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      raised_r <= FLAGS_RESET;
      flags_r  <= FLAGS_RESET;
    end else begin
      raised_r <= raised_nxt;
      flags_r  <= flags_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b_r);

  a_no_divzero_arith: assert property ((op_valid && (op_class inside {alt_addsub_packed_double,
    alt_addsub_packed_single})) |=> !raised_r[EXC_ZE]) else $error("divzero on alt addsub");
  a_horiz_mask: assert property ((op_valid && (op_class inside {horiz_add_packed_double, horiz_add_packed_single,
    horiz_sub_packed_double, horiz_sub_packed_single})) |=> raised_r == $past(detected & MASK_ARITH))
    else $error("horizontal mask wrong");
  a_moves_silent: assert property ((op_valid && (op_class inside {unaligned_wide_load, dup_low_double_move,
    dup_high_single_move, dup_low_single_move})) |=> raised_r == FLAGS_RESET) else $error("move raised");
  a_integer_silent: assert property ((op_valid && op_class == supp_integer_op) |=> raised_r == FLAGS_RESET)
    else $error("integer op raised");
  a_round_only_ip: assert property ((op_valid && (op_class inside {round_integral_packed_double,
    round_integral_packed_single, round_integral_scalar_double, round_integral_scalar_single}))
    |=> (raised_r & ~MASK_ROUND) == FLAGS_RESET) else $error("round raised D/Z/O/U");
  a_round_prec_gate: assert property ((op_valid && (op_class inside {round_integral_packed_double,
    round_integral_packed_single, round_integral_scalar_double, round_integral_scalar_single})
    && detected[EXC_PE]) |=> raised_r[EXC_PE] == !$past(imm[IMM_PREC_SUPPRESS_BIT]))
    else $error("round precision gate wrong");
  a_media_silent: assert property ((op_valid && op_class == media4_other_op) |=> raised_r == FLAGS_RESET)
    else $error("media op raised");
  a_flag_sticky: assert property (raised_r != FLAGS_RESET |-> (flags_r & raised_r) == raised_r)
    else $error("raised bit missing from flags");
  a_idle_quiet: assert property (!op_valid |=> raised_r == FLAGS_RESET) else $error("raise without op");
  a_round_no_dzou: assert property ((op_class inside {round_integral_packed_double, round_integral_packed_single,
    round_integral_scalar_double, round_integral_scalar_single}) |-> (elig_mask & ~MASK_ROUND) == MASK_NONE)
    else $error("round mask allows D/Z/O/U");
  a_dot_mask: assert property ((op_valid && (op_class inside {dot_product_double, dot_product_single}))
    |=> raised_r == $past(detected & MASK_ARITH)) else $error("dot product mask wrong");
  a_clear_idle: assert property ((!op_valid && flags_clear == ~FLAGS_RESET) |=> flags_r == FLAGS_RESET)
    else $error("clear did not empty flags");

  c_round_suppressed: cover property (op_valid && op_class == round_integral_scalar_single
    && imm[IMM_PREC_SUPPRESS_BIT] && detected[EXC_PE]);
  c_addsub_overflow: cover property (op_valid && op_class == alt_addsub_packed_single && detected[EXC_OE]);
  c_set_and_clear: cover property (raised_nxt[EXC_IE] && flags_clear[EXC_IE]);
  c_round_precision: cover property (op_valid && op_class == round_integral_packed_double
    && !imm[IMM_PREC_SUPPRESS_BIT] && detected[EXC_PE]);

endmodule

// ---- hdl/fp_excp_pkg.sv ----
// Purpose: Constants and types for the floating-point exception eligibility block
// Assumes: One clock, active-low asynchronous reset
// Notes:   Exception bit order is invalid, denormal, divzero, overflow, underflow, precision
// What this block does
// - Alternating add/sub: all but divide-by-zero
// - Horizontal add/sub: all but divide-by-zero
// - Unaligned load and duplicate moves: no exceptions
// - Supplemental integer-only ops: no exceptions
// - Round-to-integral: invalid and precision, never D/Z/O/U
// - Round precision only when immediate bit 3 clear
package fp_excp_pkg;

  localparam int EXC_W  = 6;
  localparam int EXC_IE = 0;
  localparam int EXC_DE = 1;
  localparam int EXC_ZE = 2;
  localparam int EXC_OE = 3;
  localparam int EXC_UE = 4;
  localparam int EXC_PE = 5;
  localparam int IMM_W  = 8;
  localparam int IMM_PREC_SUPPRESS_BIT = 3;

  localparam logic [EXC_W-1:0] MASK_NONE     = 6'h00;
  localparam logic [EXC_W-1:0] MASK_ARITH    = 6'h3B;
  localparam logic [EXC_W-1:0] MASK_ROUND    = 6'h21;
  localparam logic [EXC_W-1:0] MASK_ROUND_NP = 6'h01;
  localparam logic [EXC_W-1:0] FLAGS_RESET   = 6'h00;

  typedef enum logic [4:0] {
    op_none,
    alt_addsub_packed_double,
    alt_addsub_packed_single,
    horiz_add_packed_double,
    horiz_add_packed_single,
    horiz_sub_packed_double,
    horiz_sub_packed_single,
    unaligned_wide_load,
    dup_low_double_move,
    dup_high_single_move,
    dup_low_single_move,
    supp_integer_op,
    dot_product_double,
    dot_product_single,
    round_integral_packed_double,
    round_integral_packed_single,
    round_integral_scalar_double,
    round_integral_scalar_single,
    media4_other_op
  } op_class_t;

endpackage

// ---- hdl/fp_excp_decode.sv ----
// Purpose: Eligibility mask decode per operation class
// Assumes: Immediate byte valid alongside the class
// Notes:   Purely combinational
`timescale 1ns/1ps
module fp_excp_decode
  import fp_excp_pkg::*;
(
  input  fp_excp_pkg::op_class_t         op_class,
  input  wire logic [fp_excp_pkg::IMM_W-1:0] imm,
  output logic [fp_excp_pkg::EXC_W-1:0]  mask
);
  import fp_excp_pkg::*;

  wire                   is_round;
  wire                   prec_off;
  wire [EXC_W-1:0]       round_mask;

  assign is_round = (op_class == round_integral_packed_double) || (op_class == round_integral_packed_single)
                 || (op_class == round_integral_scalar_double) || (op_class == round_integral_scalar_single);
  assign prec_off = imm[IMM_PREC_SUPPRESS_BIT];
  // Precision drops out when the immediate asks for it
  assign round_mask = is_round ? (prec_off ? MASK_ROUND_NP : MASK_ROUND) : MASK_NONE;

  always_comb begin
    case (op_class)
      alt_addsub_packed_double, alt_addsub_packed_single: mask = MASK_ARITH;
      horiz_add_packed_double, horiz_add_packed_single,
      horiz_sub_packed_double, horiz_sub_packed_single:   mask = MASK_ARITH;
      dot_product_double, dot_product_single:             mask = MASK_ARITH;
      round_integral_packed_double, round_integral_packed_single,
      round_integral_scalar_double, round_integral_scalar_single:
        mask = round_mask;
      unaligned_wide_load, dup_low_double_move,
      dup_high_single_move, dup_low_single_move:          mask = MASK_NONE;
      supp_integer_op:                                    mask = MASK_NONE;
      media4_other_op:                                    mask = MASK_NONE;
      default:                                            mask = MASK_NONE;
    endcase
  end

endmodule

// ---- tb/fp_datapath_model.sv ----
// Purpose: Datapath stand-in that reports detected conditions
// Assumes: Every condition is found on every op (worst case)
// Notes:   Idle cycles carry junk that must be ignored
`timescale 1ns/1ps
module fp_datapath_model
  import fp_excp_pkg::*;
(
  input  wire logic                      op_valid,
  output logic [fp_excp_pkg::EXC_W-1:0] detected
);
  assign detected = op_valid ? 6'h3F : 6'h2A;
endmodule

// ---- tb/simd_fp_exception_eligibility_tb.sv ----
// Purpose: Self-checking bench for the exception eligibility block
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Sweeps every op class with precision bit set and clear
`timescale 1ns/1ps
module simd_fp_exception_eligibility_tb;
  import fp_excp_pkg::*;
  logic             clock, rst_b, op_valid;
  op_class_t        op_class;
  logic [IMM_W-1:0] imm;
  logic [EXC_W-1:0] detected, flags_clear, elig_mask, raised_r, flags_r, acc;
  int               n_errors, total_checks;
  fp_excp_elig u_fp_excp_elig (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_class(op_class),
    .imm(imm), .detected(detected), .flags_clear(flags_clear), .elig_mask(elig_mask),
    .raised_r(raised_r), .flags_r(flags_r));
  fp_datapath_model u_fp_datapath_model (.op_valid(op_valid), .detected(detected));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task check(string what, logic [EXC_W-1:0] seen, logic [EXC_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function logic [EXC_W-1:0] want(op_class_t c, logic [IMM_W-1:0] i);
    case (c)
      alt_addsub_packed_double, alt_addsub_packed_single, horiz_add_packed_double, horiz_add_packed_single,
      horiz_sub_packed_double, horiz_sub_packed_single, dot_product_double, dot_product_single: want = 6'h3B;
      round_integral_packed_double, round_integral_packed_single,
      round_integral_scalar_double, round_integral_scalar_single: want = i[3] ? 6'h01 : 6'h21;
      default: want = 6'h00;
    endcase
  endfunction
  // Back-to-back ops of every class, all conditions detected
  task t_classes;
    op_class_t c;
    c = c.first();
    repeat (c.num()) begin
      for (int j = 0; j < 2; j++) begin
        op_valid = 1'b1;
        op_class = c;
        imm = j ? 8'h08 : 8'hF7;
        acc = want(c, imm);
        #1 check("elig_mask", elig_mask, acc);
        @(posedge clock);
        #1 check("raised_r", raised_r, acc);
      end
      c = c.next();
    end
    op_valid = 1'b0;
    check("flags_r", flags_r, 6'h3B);
  endtask
  // Clear, idle junk ignored, then set against clear
  task t_sticky;
    flags_clear = 6'h3F;
    @(posedge clock);
    #1 check("raised_r", raised_r, 6'h00);
    check("flags_r", flags_r, 6'h00);
    op_valid = 1'b1;
    op_class = round_integral_scalar_single;
    imm = 8'h00;
    @(posedge clock);
    #1 op_valid = 1'b0;
    flags_clear = 6'h00;
    check("flags_r", flags_r, 6'h21);
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_class = op_none;
    imm = 8'h00;
    flags_clear = 6'h00;
    n_errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clock);
    #1 check("flags_r", flags_r, FLAGS_RESET);
    t_classes;
    t_sticky;
    summarize;
  end
  initial begin
    #5000;
    n_errors++;
    summarize;
  end
endmodule
